// file: src/fbre_top.sv
// Read path of a 16-bit NOR flash: asynchronous page reads and synchronous bursts.
// Assumes an AHB-Lite master on i_mclk and a host that owns the flash pins.
//
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ns

module fbre_top (
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst,
  input  wire logic                        i_hsel,
  input  wire logic [31:0]                 i_haddr,
  input  wire logic [1:0]                  i_htrans,
  input  wire logic                        i_hwrite,
  input  wire logic [2:0]                  i_hsize,
  input  wire logic [31:0]                 i_hwdata,
  input  wire logic                        i_hready,
  output logic      [31:0]                 o_hrdata,
  output logic                             o_hreadyout,
  output logic                             o_hresp,
  input  wire logic                        i_k,
  input  wire logic                        i_lat_n,
  input  wire logic                        i_ce_n,
  input  wire logic                        i_oe_n,
  input  wire logic                        i_hardware_reset_n,
  input  wire logic [fbre_pkg::ADDR_W-1:0] i_addr,
  output logic      [fbre_pkg::DATA_W-1:0] o_dq,
  output logic                             o_dq_oe,
  output logic                             o_wait,
  output logic                             o_wait_oe,
  output logic                             o_standby
);
  import fbre_pkg::*;

  logic [SYNC_W-1:0] pin_s;
  logic [SYNC_W-1:0] pin_prev_q;
  logic [ADDR_W-1:0] a_s;
  logic              k_s, lat_n_s, ce_n_s, oe_n_s, hrst_s;
  logic [15:0]       cfg_q;
  fbre_tgt_e         tgt_q;
  logic [15:0]       statv_q;
  logic [15:0]       query_q;
  logic [15:0]       mem [MEM_WORDS];
  logic              pend_q, wr_q;
  logic [11:0]       a_q;
  fbre_st_e          st_q, st_d_q;
  logic [ADDR_W-1:0] addr_q, start_q;
  logic [2:0]        cnt_q;
  logic [3:0]        words_q, edg_q;
  logic              hold_ph_q, waited_q, arm_q;
  logic [5:0]        page_q;
  logic [ADDR_W-1:0] last_a_q;
  logic              page_ok_q;
  logic [4:0]        dly_q, idle_q;
  logic              wait_act, k_act, act;
  logic [2:0]        lat_eff;
  logic              async_md, wrap_en, pin_wait, edge_rise, hold2, wpol;

  fbre_seq_if sif ();

  fbre_sync u_sync (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_async ({i_hardware_reset_n, i_oe_n, i_ce_n, i_lat_n, i_k, i_addr}),
    .o_sync  (pin_s)
  );

  fbre_seq u_seq (
    .sif (sif)
  );

  assign a_s       = pin_s[ADDR_W-1:0];
  assign k_s       = pin_s[PIN_K];
  assign lat_n_s   = pin_s[PIN_LAT];
  assign ce_n_s    = pin_s[PIN_CE];
  assign oe_n_s    = pin_s[PIN_OE];
  assign hrst_s    = pin_s[PIN_HRST];
  assign async_md  = cfg_q[CFG_RMODE];
  assign wrap_en   = ~cfg_q[CFG_WRAP];
  assign pin_wait  = ~cfg_q[CFG_PINFN];
  assign edge_rise = cfg_q[CFG_EDGE];
  assign hold2     = cfg_q[CFG_HOLD];
  assign wpol      = cfg_q[CFG_WPOL];
  assign lat_eff   = (cfg_q[CFG_LAT_LSB +: 3] < LAT_MIN) ? LAT_MIN : cfg_q[CFG_LAT_LSB +: 3];
  assign sif.cur      = addr_q;
  assign sif.len_code = cfg_q[CFG_BL_LSB +: 3];
  assign sif.wrap_en  = wrap_en;
  assign o_hresp   = 1'b0;

  // Data seen at the pins for the last command target.
  function automatic logic [15:0] src_word(input logic [ADDR_W-1:0] a);
    case (tgt_q)
      TGT_STATUS: src_word = statv_q;
      TGT_QUERY:  src_word = query_q;
      TGT_SIG:    src_word = SIG_CODE;
      default:    src_word = mem[a[5:0]];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave with one wait state, so that read data leaves a flip-flop.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pend_q      <= 1'b0;
      wr_q        <= 1'b0;
      a_q         <= 12'h000;
      o_hreadyout <= 1'b1;
    end else if (i_hsel && i_htrans[1] && i_hready) begin
      pend_q      <= 1'b1;
      wr_q        <= i_hwrite && (i_hsize == HSIZE_WORD);
      a_q         <= i_haddr[11:0];
      o_hreadyout <= 1'b0;
    end else if (pend_q) begin
      pend_q      <= 1'b0;
      o_hreadyout <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || !hrst_s) begin
      cfg_q   <= CFG_RST;
      tgt_q   <= TGT_ARRAY;
      statv_q <= 16'h0000;
      query_q <= 16'h0000;
    end else if (pend_q && wr_q) begin
      if (a_q == OFS_CFG) begin
        cfg_q <= i_hwdata[15:0] & CFG_WMASK;
      end else if (a_q == OFS_TGT) begin
        tgt_q <= fbre_tgt_e'(i_hwdata[1:0]);
      end else if (a_q == OFS_STATV) begin
        statv_q <= i_hwdata[15:0];
      end else if (a_q == OFS_QUERY) begin
        query_q <= i_hwdata[15:0];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (pend_q && wr_q && a_q >= OFS_MEM_LO && a_q <= OFS_MEM_HI) begin
      mem[a_q[7:2]] <= i_hwdata[15:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_hrdata <= 32'h0000_0000;
    end else if (pend_q && !wr_q) begin
      if (a_q == OFS_CFG) begin
        o_hrdata <= {16'h0000, cfg_q};
      end else if (a_q == OFS_TGT) begin
        o_hrdata <= {30'h0000_0000, tgt_q};
      end else if (a_q == OFS_STATV) begin
        o_hrdata <= {16'h0000, statv_q};
      end else if (a_q == OFS_QUERY) begin
        o_hrdata <= {16'h0000, query_q};
      end else if (a_q == OFS_STATE) begin
        o_hrdata <= {15'h0000, waited_q, o_standby, st_q, words_q, addr_q};
      end else if (a_q >= OFS_MEM_LO && a_q <= OFS_MEM_HI) begin
        o_hrdata <= {16'h0000, mem[a_q[7:2]]};
      end else begin
        o_hrdata <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Link clock edge detection and latch arming.
  assign k_act = edge_rise ? (k_s && !pin_prev_q[PIN_K]) : (!k_s && pin_prev_q[PIN_K]);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      pin_prev_q <= {SYNC_W{1'b1}};
    end else begin
      pin_prev_q <= pin_s;
    end
  end

  // Armed by the later of the two falling edges, taken by the next active edge.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      arm_q <= 1'b0;
    end else if ((!lat_n_s && pin_prev_q[PIN_LAT]) || (!ce_n_s && pin_prev_q[PIN_CE])) begin
      arm_q <= 1'b1;
    end else if (k_act) begin
      arm_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Burst controller. A halted link clock simply freezes it, which is the suspend.
  always_ff @(posedge i_mclk) begin
    if (i_rst || !hrst_s || ce_n_s || async_md) begin
      st_q      <= ST_IDLE;
      addr_q    <= 8'h00;
      start_q   <= 8'h00;
      cnt_q     <= 3'h0;
      words_q   <= 4'h0;
      hold_ph_q <= 1'b0;
      waited_q  <= 1'b0;
    end else if (k_act && arm_q && !lat_n_s) begin
      st_q      <= ST_LAT;
      addr_q    <= a_s;
      start_q   <= a_s;
      cnt_q     <= lat_eff - 3'h1;
      words_q   <= 4'h0;
      hold_ph_q <= 1'b0;
      waited_q  <= 1'b0;
    end else if (k_act) begin
      case (st_q)
        ST_LAT: begin
          if (cnt_q == 3'h1) begin
            st_q <= ST_DATA;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        ST_DATA: begin
          if (hold2 && !hold_ph_q) begin
            hold_ph_q <= 1'b1;
          end else begin
            hold_ph_q <= 1'b0;
            if (sif.fixed && words_q == sif.last_idx) begin
              st_q <= ST_END;
            end else begin
              words_q <= words_q + 4'h1;
              addr_q  <= sif.nxt;
              if (sif.cross16 && !waited_q && start_q[1:0] != 2'h0) begin
                st_q     <= ST_BWAIT;
                cnt_q    <= {1'b0, start_q[1:0]};
                waited_q <= 1'b1;
              end
            end
          end
        end
        ST_BWAIT: begin
          if (cnt_q == 3'h1) begin
            st_q <= ST_DATA;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Asynchronous page access; the host must have selected this mode first.
  always_ff @(posedge i_mclk) begin
    if (i_rst || !async_md || ce_n_s) begin
      page_ok_q <= 1'b0;
      page_q    <= 6'h00;
      last_a_q  <= 8'h00;
      dly_q     <= 5'h00;
    end else if (a_s != last_a_q || !page_ok_q) begin
      last_a_q  <= a_s;
      page_q    <= a_s[7:2];
      page_ok_q <= 1'b1;
      dly_q     <= (page_ok_q && a_s[7:2] == page_q) ? PAGE_CYC : RAND_CYC;
    end else if (dly_q != 5'h00) begin
      dly_q <= dly_q - 5'h01;
    end
  end

  // Standby only saves power; the outputs keep being driven.
  assign act = (pin_s[SYNC_W-1:PIN_LAT] != pin_prev_q[SYNC_W-1:PIN_LAT])
             || (a_s != pin_prev_q[ADDR_W-1:0]);

  always_ff @(posedge i_mclk) begin
    if (i_rst || !async_md || act) begin
      idle_q    <= 5'h00;
      o_standby <= 1'b0;
    end else if (idle_q == STBY_CYC - 5'h01) begin
      o_standby <= 1'b1;
    end else begin
      idle_q <= idle_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers.
  assign wait_act = !async_md && !oe_n_s
                  && (st_q == ST_LAT || st_q == ST_BWAIT || st_q == ST_END);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_dq      <= 16'h0000;
      o_dq_oe   <= 1'b0;
      o_wait    <= 1'b0;
      o_wait_oe <= 1'b0;
    end else begin
      if (!async_md) begin
        o_dq <= src_word(addr_q);
      end else if (dly_q == 5'h01) begin
        o_dq <= src_word(a_s);
      end
      o_dq_oe   <= !ce_n_s && !oe_n_s && hrst_s;
      o_wait    <= wpol ? wait_act : !wait_act;
      o_wait_oe <= pin_wait && !ce_n_s && !oe_n_s && hrst_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_d_q <= ST_IDLE;
      edg_q  <= 4'h0;
    end else begin
      st_d_q <= st_q;
      edg_q  <= (st_q != st_d_q) ? 4'(k_act) : edg_q + 4'(k_act);
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  sequence s_lat_exit;
    (st_d_q == ST_LAT) ##0 (st_q == ST_DATA);
  endsequence
  sequence s_bw_exit;
    (st_d_q == ST_BWAIT) ##0 (st_q == ST_DATA);
  endsequence

  AST_FIXED_LEN: assert property (
    (st_q == ST_END && st_d_q == ST_DATA) |-> words_q == sif.last_idx)
    else $error("fixed burst ended at wrong word count");
  AST_BWAIT_CLKS: assert property (
    s_bw_exit |-> edg_q == 4'(start_q[1:0]))
    else $error("boundary wait length differs from start offset");
  AST_BWAIT_ONCE: assert property (
    (st_q == ST_BWAIT && st_d_q != ST_BWAIT) |-> !$past(waited_q))
    else $error("boundary wait inserted twice");
  AST_WRAP_INSIDE: assert property (
    (st_q == ST_DATA && sif.fixed && wrap_en)
      |-> ((addr_q ^ start_q) & ~{4'h0, sif.last_idx}) == 8'h00)
    else $error("wrapped burst left its block");
  AST_LINEAR: assert property (
    (st_q == ST_DATA && st_d_q == ST_DATA && $changed(addr_q) && !(sif.fixed && wrap_en))
      |-> addr_q == 8'($past(addr_q) + 8'h01))
    else $error("linear burst skipped an address");
  AST_RSV_ZERO: assert property (
    (pend_q && wr_q && a_q == OFS_CFG) |=> !cfg_q[CFG_RSV_HI] && !cfg_q[CFG_RSV_LO])
    else $error("reserved configuration bit took a value");
  AST_STANDBY: assert property (
    act |=> (!o_standby) [*8])
    else $error("standby entered too soon after activity");
  AST_ASYNC_NOWAIT: assert property (
    ($past(async_md) && o_wait_oe) |-> o_wait == !$past(wpol))
    else $error("wait asserted in asynchronous mode");
  AST_LATCH_EDGE: assert property (
    (st_q == ST_LAT && st_d_q != ST_LAT) |-> $past(k_act))
    else $error("burst started off the selected clock edge");
  AST_HOLD2: assert property (
    (st_q == ST_DATA && k_act && hold2 && !hold_ph_q && !ce_n_s && !async_md && lat_n_s)
      |=> $stable(addr_q) && st_q == ST_DATA)
    else $error("word not held for two clocks");
  AST_WAIT_END: assert property (
    (st_q == ST_END && !oe_n_s && !async_md) |=> o_wait == $past(wpol))
    else $error("wait not asserted at burst end");
  AST_WAIT_GATE: assert property (
    oe_n_s |=> !o_wait_oe && !o_dq_oe)
    else $error("pins driven while output enable high");
  AST_LATENCY: assert property (
    s_lat_exit |-> edg_q == 4'(lat_eff) - 4'h1)
    else $error("first data at wrong latency");

endmodule

// file: src/fbre_pkg.sv
// Shared constants and types of the flash burst read engine.
// Assumes a 125 MHz system clock and a single AHB-Lite master.
package fbre_pkg;

  localparam int          CLK_NS      = 8;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 16;
  localparam int          MEM_WORDS   = 64;
  localparam int          SYNC_W      = 13;

  ////////////////////////////////////////////////////////////////////////////////
  // Register offsets, byte addresses within the slave window.
  localparam logic [11:0] OFS_CFG     = 12'h000;
  localparam logic [11:0] OFS_TGT     = 12'h004;
  localparam logic [11:0] OFS_STATV   = 12'h008;
  localparam logic [11:0] OFS_QUERY   = 12'h00C;
  localparam logic [11:0] OFS_STATE   = 12'h010;
  localparam logic [11:0] OFS_MEM_LO  = 12'h100;
  localparam logic [11:0] OFS_MEM_HI  = 12'h1FC;
  localparam logic [2:0]  HSIZE_WORD  = 3'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration word fields and values.
  localparam int          CFG_BL_LSB  = 0;
  localparam int          CFG_WRAP    = 3;
  localparam int          CFG_PINFN   = 4;
  localparam int          CFG_RSV_LO  = 5;
  localparam int          CFG_EDGE    = 6;
  localparam int          CFG_HOLD    = 9;
  localparam int          CFG_WPOL    = 10;
  localparam int          CFG_LAT_LSB = 11;
  localparam int          CFG_RSV_HI  = 14;
  localparam int          CFG_RMODE   = 15;
  localparam logic [15:0] CFG_RST     = 16'h3DDF;
  localparam logic [15:0] CFG_WMASK   = 16'hBFDF;
  localparam logic [2:0]  BL_4W       = 3'h1;
  localparam logic [2:0]  BL_8W       = 3'h2;
  localparam logic [2:0]  BL_CONT     = 3'h7;
  localparam logic [2:0]  LAT_MIN     = 3'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Positions of the synchronised pins; the address occupies the low bits.
  localparam int          PIN_K       = 8;
  localparam int          PIN_LAT     = 9;
  localparam int          PIN_CE      = 10;
  localparam int          PIN_OE      = 11;
  localparam int          PIN_HRST    = 12;

  ////////////////////////////////////////////////////////////////////////////////
  // Times and derived cycle counts, rounded up.
  localparam int          STBY_NS     = 150;
  localparam int          RAND_NS     = 80;
  localparam int          PAGE_NS     = 24;
  localparam logic [4:0]  STBY_CYC    = 5'((STBY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0]  RAND_CYC    = 5'((RAND_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [4:0]  PAGE_CYC    = 5'((PAGE_NS + CLK_NS - 1) / CLK_NS);

  // Signature value is arbitrary.
  localparam logic [15:0] SIG_CODE    = 16'h5A01;

  typedef enum logic [1:0] {TGT_ARRAY, TGT_STATUS, TGT_QUERY, TGT_SIG} fbre_tgt_e;
  typedef enum logic [2:0] {ST_IDLE, ST_LAT, ST_DATA, ST_BWAIT, ST_END} fbre_st_e;

endpackage

// file: src/fbre_seq_if.sv
// Carrier between the burst controller and its address sequencer.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ns
interface fbre_seq_if;
  logic [fbre_pkg::ADDR_W-1:0] cur;
  logic [2:0]                  len_code;
  logic                        wrap_en;
  logic [fbre_pkg::ADDR_W-1:0] nxt;
  logic                        cross16;
  logic                        fixed;
  logic [3:0]                  last_idx;
  modport ctl (output cur, len_code, wrap_en, input nxt, cross16, fixed, last_idx);
  modport seq (input cur, len_code, wrap_en, output nxt, cross16, fixed, last_idx);
endinterface

// file: src/fbre_seq.sv
// Next-address logic of a synchronous burst.
// Assumes the controller holds the current word address on the carrier.
`timescale 1ns/1ns
module fbre_seq (
  fbre_seq_if.seq sif
);
  import fbre_pkg::*;

  logic [ADDR_W-1:0] lin;
  logic [ADDR_W-1:0] msk;

  always_comb begin
    lin          = sif.cur + 8'h01;
    msk          = (sif.len_code == BL_4W) ? 8'h03 : (sif.len_code == BL_8W) ? 8'h07 : 8'h0F;
    sif.fixed    = (sif.len_code != BL_CONT);
    sif.last_idx = msk[3:0];
    if (sif.fixed && sif.wrap_en) begin
      // Stay inside the aligned block; an aligned start gives the linear order.
      sif.nxt     = (sif.cur & ~msk) | (lin & msk);
      sif.cross16 = 1'b0;
    end else begin
      sif.nxt     = lin;
      sif.cross16 = (lin[3:0] == 4'h0);
    end
  end

endmodule

// file: src/fbre_sync.sv
// Two-stage synchronisers for every pin that enters the system clock domain.
// Assumes pins idle high after reset.
`timescale 1ns/1ns
module fbre_sync (
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst,
  input  wire logic [fbre_pkg::SYNC_W-1:0] i_async,
  output logic      [fbre_pkg::SYNC_W-1:0] o_sync
);
  import fbre_pkg::*;

  logic [SYNC_W-1:0] meta_q;

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_bit
      always_ff @(posedge i_mclk) begin
        if (i_rst) begin
          meta_q[g] <= 1'b1;
          o_sync[g] <= 1'b1;
        end else begin
          meta_q[g] <= i_async[g];
          o_sync[g] <= meta_q[g];
        end
      end
    end
  endgenerate

endmodule

// file: sim/fbre_host_model.sv
// Host-side model of the flash pins: bus clock, strobes and word address.
// Assumes the bench calls one task at a time and reads the results afterwards.
`timescale 1ns/1ns
module fbre_host_model (
  output logic             o_k,
  output logic             o_lat_n,
  output logic             o_ce_n,
  output logic             o_oe_n,
  output logic [7:0]       o_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_dq_oe,
  input  wire logic        i_wait,
  input  wire logic        i_wait_oe
);
  logic [15:0] got[$];
  int          waits;
  int          first;
  logic        rel;
  initial begin
    o_k = 1'b0;
    o_lat_n = 1'b1;
    o_ce_n = 1'b1;
    o_oe_n = 1'b1;
    o_addr = 8'hFF;
  end
  // The clock stands still outside frames; pins are steady around the latching edge.
  task automatic burst(input logic [7:0] a, input logic pol, input int sus);
    int pend;
    got.delete();
    waits = 0;
    first = -1;
    pend = 0;
    o_addr = a;
    o_ce_n = 1'b0;
    o_oe_n = 1'b0;
    o_lat_n = 1'b0;
    #80 o_k = 1'b1;
    #80 o_k = 1'b0;
    o_lat_n = 1'b1;
    o_addr = ~a;
    for (int e = 1; e < 32; e++) begin
      #80 o_k = 1'b1;
      #80 o_k = 1'b0;
      if (i_wait === pol) begin
        pend++;
      end else if (i_dq_oe === 1'b1) begin
        if (first < 0) first = e;
        else waits += pend;
        pend = 0;
        got.push_back(i_dq);
      end
      // Suspend: clock halted low, output enable raised, chip enable kept low.
      if (e == sus) begin
        o_oe_n = 1'b1;
        #400 rel = i_dq_oe | i_wait_oe;
        o_oe_n = 1'b0;
        #80;
      end
    end
    o_ce_n = 1'b1;
    o_oe_n = 1'b1;
  endtask
  task automatic aread(input logic [7:0] a, output logic [15:0] d);
    o_addr = a;
    o_ce_n = 1'b0;
    o_oe_n = 1'b0;
    #200 d = i_dq;
  endtask
endmodule

// file: sim/fbre_top_tb.sv
// Self-checking bench of the flash burst read engine.
// Assumes the host model owns the flash pins and the bench is the AHB-Lite master.
`timescale 1ns/1ns
module fbre_top_tb;
  import fbre_pkg::*;
  logic        i_mclk, i_rst, hsel, hwrite, hready, hresp;
  logic [1:0]  htrans;
  logic [2:0]  hsize, lat;
  logic [31:0] haddr, hwdata, hrdata, seed, rd;
  logic        k, lat_n, ce_n, oe_n, dq_oe, wt, wt_oe, stby, pol;
  logic [7:0]  addr;
  logic [15:0] dq, d, mem[64];
  logic [7:0]  st[10] = '{8'h07, 8'h0D, 8'h03, 8'h03, 8'h10, 8'h10, 8'h01, 8'h0E, 8'h00, 8'h00};
  logic [2:0]  bl[10] = '{BL_8W, BL_4W, BL_CONT, BL_CONT, 3'h3, 3'h3, 3'h3, BL_4W, 3'h1, 3'h1};
  logic        nw[10] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
  int          num_errors, checks, len, n;
  fbre_top u_fbre_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_k(k), .i_lat_n(lat_n),
    .i_ce_n(ce_n), .i_oe_n(oe_n), .i_hardware_reset_n(1'b1), .i_addr(addr), .o_dq(dq),
    .o_dq_oe(dq_oe), .o_wait(wt), .o_wait_oe(wt_oe), .o_standby(stby));
  fbre_host_model u_host (.o_k(k), .o_lat_n(lat_n), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_addr(addr),
    .i_dq(dq), .i_dq_oe(dq_oe), .i_wait(wt), .i_wait_oe(wt_oe));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
  endfunction
  function automatic logic [31:0] cfgw(logic rm, logic [2:0] lt, logic pl, logic w, logic [2:0] b);
    return {16'h0, rm, 1'b0, lt, pl, 3'h3, 1'b1, 2'h0, w, b};
  endfunction
  // Wrapped fixed bursts stay inside their aligned block; the rest run linearly.
  function automatic logic [7:0] ea(logic [7:0] s, int ln, logic w, int i);
    if (!w && ln != 0) return (s & ~8'(ln - 1)) | ((s + 8'(i)) & 8'(ln - 1));
    return s + 8'(i);
  endfunction
  // A boundary wait of start mod 4 clocks, once, when the first 16-word boundary is crossed.
  function automatic int ew(logic [7:0] s, int ln, logic w);
    return (ln == 0 || (w && int'(s[3:0]) + ln > 16)) ? int'(s[1:0]) : 0;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] dat);
    @(posedge i_mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge i_mclk);
    while (hready !== 1'b1) @(posedge i_mclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= dat;
    @(posedge i_mclk);
    while (hready !== 1'b1) @(posedge i_mclk);
    rd = hrdata;
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    {i_rst, hsel, hwrite, htrans, haddr, hwdata, hsize} = {1'b1, 68'h0, HSIZE_WORD};
    seed = 32'h0001411E;
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    ahb(1'b0, 32'(OFS_CFG), 32'h0);
    chk(rd, 32'(CFG_RST));
    ahb(1'b1, 32'(OFS_CFG), 32'hFFFF);
    ahb(1'b0, 32'(OFS_CFG), 32'h0);
    chk(rd, 32'(CFG_WMASK));
    ahb(1'b0, 32'h00000080, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 64; i++) begin
      seed = lfsr(seed);
      mem[i] = seed[15:0];
      ahb(1'b1, 32'(OFS_MEM_LO) + 32'(4 * i), {16'h0, mem[i]});
    end
    $display("register test done");
    // Bursts read the array only; the target stays at its reset value here.
    for (int i = 0; i < 10; i++) begin
      if (i > 7) begin
        seed = lfsr(seed);
        st[i] = {3'h0, seed[4:0]};
        bl[i] = (seed[7:6] == 2'h3) ? BL_CONT : {1'b0, seed[7:6] + 2'h1};
        nw[i] = seed[8];
      end
      lat = 3'(2 + i % 6);
      pol = (i != 3);
      ahb(1'b1, 32'(OFS_CFG), cfgw(1'b0, lat, pol, nw[i], bl[i]));
      u_host.burst(st[i], pol, (i % 2) ? 2 : 6);
      len = (bl[i] == BL_CONT) ? 0 : (2 << bl[i]);
      n = (len != 0) ? len : 20;
      chk(32'(u_host.first), 32'(lat) - 32'h1);
      chk((len != 0) ? 32'(u_host.got.size()) : 32'(u_host.got.size() >= 20 ? 20 : 0), 32'(n));
      for (int j = 0; j < n && j < u_host.got.size(); j++) begin
        chk({16'h0, u_host.got[j]}, {16'h0, mem[ea(st[i], len, nw[i], j) % 64]});
      end
      chk(32'(u_host.waits), 32'(ew(st[i], len, nw[i])));
      chk({31'h0, u_host.rel}, 32'h0);
      $display("burst test %0d done", i);
    end
    ahb(1'b1, 32'(OFS_CFG), cfgw(1'b1, 3'h7, 1'b1, 1'b1, BL_CONT));
    ahb(1'b1, 32'(OFS_STATV), 32'h0000A5C3);
    ahb(1'b1, 32'(OFS_QUERY), 32'h00003C96);
    for (int t = 0; t < 4; t++) begin
      ahb(1'b1, 32'(OFS_TGT), 32'(t));
      u_host.aread(8'(t * 5), d);
      chk({16'h0, d}, {16'h0, t == 0 ? mem[0] : t == 1 ? 16'hA5C3 : t == 2 ? 16'h3C96 : SIG_CODE});
      #300;
      chk({30'h0, stby, dq_oe}, 32'h3);
      chk({31'h0, wt}, 32'h0);
    end
    $display("async test done");
    report_and_stop();
  end
endmodule
